// *** core/system_command_handler.sv ***
// system command handler with its outgoing message fifo
// assumes commands arrive decoded on the system clock and settings storage is
// reached through simple request/done strobes on the same clock
`timescale 1ns/1ps
`default_nettype none

// message fifo; flop storage indexed by pointers
module msg_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk_sys, // system clock
	input wire logic reset, // synchronous, active high
	input wire logic in_valid, // write request
	output logic in_ready, // space available
	input wire logic [WIDTH-1:0] in_data, // write word
	output logic out_valid, // word available
	input wire logic out_ready, // reader takes word
	output logic [WIDTH-1:0] out_data // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_reg;
	logic [AW:0] rd_ptr_reg;
	logic push;
	logic pop;

	// pointer wrap trick only works for power-of-two depths
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
		$error("msg_fifo depth must be a power of two of at least 2");
	end

	// full when pointers differ only in the wrap bit
	assign in_ready = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
		(wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr_reg[AW-1:0]];

	// storage, no reset needed since reads are gated by out_valid
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end

	// pointers
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (push)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule // msg_fifo

module system_command_handler #(
	parameter int FIFO_DEPTH = 32
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic reset, // synchronous, active high
	input wire logic parse_mode, // 0 text, 1 binary
	input wire sys_cmd_pkg::cmd_t cmd_data, // decoded command
	input wire logic cmd_valid, // command offered
	output logic cmd_ready, // command taken when valid
	output sys_cmd_pkg::msg_t msg_data, // response or event
	output logic msg_valid, // message offered
	input wire logic msg_ready, // transport takes message
	output logic restart_req, // one-cycle restart request
	input wire logic restart_done, // restart finished
	output logic save_req, // one-cycle settings save request
	input wire logic save_done, // save finished
	output logic defaults_req, // one-cycle factory load request
	input wire logic defaults_done, // factory load finished
	output logic rd_req, // one-cycle readout fetch
	output logic [1:0] rd_sel, // readout area selector
	output logic [15:0] rd_addr, // readout byte offset
	input wire logic [127:0] rd_data, // 16 bytes, one cycle after rd_req
	output logic [31:0] runtime_sec, // seconds since boot
	output logic [15:0] runtime_frac // 1/32768 second units
);
	localparam logic [27:0] DIV_STEP = 28'(sys_cmd_pkg::WATCH_HZ);
	localparam logic [27:0] DIV_WRAP = 28'(sys_cmd_pkg::CLK_HZ);

	sys_cmd_pkg::state_t state_reg;
	sys_cmd_pkg::cmd_t cmd_reg;
	sys_cmd_pkg::msg_t out_reg;
	logic [27:0] div_acc_reg;
	logic watch_tick;
	logic [31:0] sec_reg;
	logic [15:0] frac_reg;
	logic [15:0] total_reg;
	logic [15:0] offset_reg;
	logic [15:0] remain;
	logic [15:0] chunk_len;
	logic [15:0] resp_len;
	logic [15:0] resp_result;
	logic fifo_in_ready;
	logic pushing;
	logic clear_time;
	logic cmd_take;

	// refused at elaboration, the fifo cannot serve smaller depths
	if (FIFO_DEPTH < 2) begin : g_bad_fifo
		$error("system_command_handler needs a fifo depth of at least 2");
	end

	// watch tick: fractional divider keeps the long-run rate exact at 32768 Hz
	// a restart also restarts the divider, so runtime after boot starts in phase
	always_ff @(posedge clk_sys) begin
		if (reset || clear_time)
			div_acc_reg <= '0;
		else if (div_acc_reg + DIV_STEP >= DIV_WRAP)
			div_acc_reg <= div_acc_reg + DIV_STEP - DIV_WRAP; // RULE_04
		else
			div_acc_reg <= div_acc_reg + DIV_STEP;
	end
	assign watch_tick = (div_acc_reg + DIV_STEP >= DIV_WRAP);

	// runtime since boot; only reset or a restart clears it, queries never touch it
	always_ff @(posedge clk_sys) begin
		if (reset || clear_time) begin
			sec_reg <= '0;
			frac_reg <= '0;
		end else if (watch_tick) begin
			if (frac_reg == sys_cmd_pkg::FRAC_LAST) begin
				frac_reg <= '0;
				sec_reg <= sec_reg + 1'b1; // RULE_02
			end else begin
				frac_reg <= frac_reg + 1'b1; // RULE_03
			end
		end
	end
	assign runtime_sec = sec_reg;
	assign runtime_frac = frac_reg;
	assign clear_time = state_reg == sys_cmd_pkg::S_REBOOT && restart_done;

	// commands are taken only from idle, so nothing overlaps a sequence
	assign cmd_ready = state_reg == sys_cmd_pkg::S_IDLE;
	assign cmd_take = cmd_valid && cmd_ready;
	always_ff @(posedge clk_sys) begin
		if (reset)
			cmd_reg <= '0;
		else if (cmd_take)
			cmd_reg <= cmd_data;
	end

	// response result and length per identifier
	always_comb begin
		resp_result = sys_cmd_pkg::RES_OK;
		resp_len = '0;
		if (cmd_data.group != sys_cmd_pkg::GROUP_SYSTEM ||
			cmd_data.id < sys_cmd_pkg::CMD_PING ||
			cmd_data.id > sys_cmd_pkg::CMD_DEFAULTS)
			resp_result = sys_cmd_pkg::RES_UNKNOWN_CMD; // RULE_17
		else if (cmd_data.id == sys_cmd_pkg::CMD_READOUT) begin
			if (cmd_data.arg > 8'(sys_cmd_pkg::SEL_STATE))
				resp_result = sys_cmd_pkg::RES_BAD_VALUE; // RULE_09
			else if (cmd_data.arg[1:0] == sys_cmd_pkg::SEL_STATE)
				resp_len = sys_cmd_pkg::LEN_STATE; // RULE_10
			else
				resp_len = sys_cmd_pkg::LEN_CONFIG; // RULE_10
		end
	end

	// readout progress
	assign remain = total_reg - offset_reg;
	assign chunk_len = (remain > sys_cmd_pkg::CHUNK_MAX) ? sys_cmd_pkg::CHUNK_MAX : remain; // RULE_08
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			total_reg <= '0;
			offset_reg <= '0;
			rd_sel <= '0;
		end else if (cmd_take) begin
			total_reg <= resp_len;
			offset_reg <= '0;
			rd_sel <= cmd_data.arg[1:0]; // RULE_09
		end else if (state_reg == sys_cmd_pkg::S_CHUNK && pushing) begin
			offset_reg <= offset_reg + chunk_len;
		end
	end
	assign rd_addr = offset_reg;

	// outgoing message; built one state ahead so it is a flop when pushed
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			// boot state pushes at once after release, so the startup event must be ready
			out_reg <= '0;
			out_reg.fmt <= parse_mode;
			out_reg.is_event <= 1'b1;
			out_reg.group <= sys_cmd_pkg::GROUP_SYSTEM;
			out_reg.id <= sys_cmd_pkg::EVT_BOOT; // RULE_07
		end else if (cmd_take) begin
			out_reg <= '0;
			out_reg.fmt <= parse_mode; // RULE_16
			out_reg.group <= cmd_data.group;
			out_reg.id <= cmd_data.id; // RULE_17
			out_reg.result <= resp_result;
			out_reg.len <= resp_len; // RULE_10
			out_reg.payload[47:0] <= {sec_reg, frac_reg}; // RULE_01
		end else if (state_reg == sys_cmd_pkg::S_RDWAIT) begin
			out_reg <= '0;
			out_reg.fmt <= parse_mode;
			out_reg.is_event <= 1'b1;
			out_reg.group <= sys_cmd_pkg::GROUP_SYSTEM;
			out_reg.id <= sys_cmd_pkg::EVT_CHUNK; // RULE_08
			out_reg.len <= chunk_len;
			out_reg.payload <= rd_data;
		end else if (state_reg == sys_cmd_pkg::S_DEFLT && defaults_done) begin
			out_reg <= '0;
			out_reg.fmt <= parse_mode;
			out_reg.is_event <= 1'b1;
			out_reg.group <= sys_cmd_pkg::GROUP_SYSTEM;
			out_reg.id <= sys_cmd_pkg::EVT_RESTORE_DONE; // RULE_15
		end else if (clear_time || state_reg == sys_cmd_pkg::S_IDLE) begin
			out_reg <= '0;
			out_reg.fmt <= parse_mode;
			out_reg.is_event <= 1'b1;
			out_reg.group <= sys_cmd_pkg::GROUP_SYSTEM;
			out_reg.id <= sys_cmd_pkg::EVT_BOOT; // RULE_07
		end
	end

	// pushing waits on fifo space, so a slow transport stalls the sequence
	assign pushing = fifo_in_ready && (state_reg == sys_cmd_pkg::S_RESP ||
		state_reg == sys_cmd_pkg::S_CHUNK || state_reg == sys_cmd_pkg::S_DONEV ||
		state_reg == sys_cmd_pkg::S_BOOT);

	// sequencer
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_reg <= sys_cmd_pkg::S_BOOT;
		end else begin
			unique case (state_reg)
				sys_cmd_pkg::S_IDLE: begin
					if (cmd_take)
						state_reg <= (resp_result == sys_cmd_pkg::RES_OK &&
							cmd_data.id == sys_cmd_pkg::CMD_SAVE) ?
							sys_cmd_pkg::S_SAVE : sys_cmd_pkg::S_RESP; // RULE_05
				end
				sys_cmd_pkg::S_SAVE: begin
					if (save_done)
						state_reg <= sys_cmd_pkg::S_RESP; // RULE_11
				end
				sys_cmd_pkg::S_RESP: begin
					if (pushing) begin // RULE_18
						if (out_reg.result != sys_cmd_pkg::RES_OK)
							state_reg <= sys_cmd_pkg::S_IDLE;
						else if (cmd_reg.id == sys_cmd_pkg::CMD_RESTART)
							state_reg <= sys_cmd_pkg::S_REBOOT; // RULE_06
						else if (cmd_reg.id == sys_cmd_pkg::CMD_READOUT)
							state_reg <= sys_cmd_pkg::S_RDREQ; // RULE_08
						else if (cmd_reg.id == sys_cmd_pkg::CMD_DEFAULTS)
							state_reg <= sys_cmd_pkg::S_DEFLT; // RULE_13
						else
							state_reg <= sys_cmd_pkg::S_IDLE;
					end
				end
				sys_cmd_pkg::S_RDREQ: state_reg <= sys_cmd_pkg::S_RDWAIT;
				sys_cmd_pkg::S_RDWAIT: state_reg <= sys_cmd_pkg::S_CHUNK;
				sys_cmd_pkg::S_CHUNK: begin
					if (pushing)
						state_reg <= (remain > chunk_len) ?
							sys_cmd_pkg::S_RDREQ : sys_cmd_pkg::S_IDLE; // RULE_08
				end
				sys_cmd_pkg::S_DEFLT: begin
					if (defaults_done)
						state_reg <= sys_cmd_pkg::S_DONEV; // RULE_13
				end
				sys_cmd_pkg::S_DONEV: begin
					if (pushing)
						state_reg <= sys_cmd_pkg::S_REBOOT; // RULE_15
				end
				sys_cmd_pkg::S_REBOOT: begin
					if (restart_done)
						state_reg <= sys_cmd_pkg::S_BOOT; // RULE_07
				end
				sys_cmd_pkg::S_BOOT: begin
					if (pushing)
						state_reg <= sys_cmd_pkg::S_IDLE;
				end
			endcase
		end
	end

	// request strobes, one cycle each, raised on entry to the waiting state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			restart_req <= 1'b0;
			save_req <= 1'b0;
			defaults_req <= 1'b0;
			rd_req <= 1'b0;
		end else begin
			restart_req <= pushing && (state_reg == sys_cmd_pkg::S_DONEV ||
				(state_reg == sys_cmd_pkg::S_RESP && out_reg.result == sys_cmd_pkg::RES_OK &&
				cmd_reg.id == sys_cmd_pkg::CMD_RESTART)); // RULE_06
			save_req <= cmd_take && resp_result == sys_cmd_pkg::RES_OK &&
				cmd_data.id == sys_cmd_pkg::CMD_SAVE; // RULE_11
			defaults_req <= pushing && state_reg == sys_cmd_pkg::S_RESP &&
				out_reg.result == sys_cmd_pkg::RES_OK &&
				cmd_reg.id == sys_cmd_pkg::CMD_DEFAULTS; // RULE_13
			rd_req <= (pushing && state_reg == sys_cmd_pkg::S_RESP &&
				out_reg.result == sys_cmd_pkg::RES_OK &&
				cmd_reg.id == sys_cmd_pkg::CMD_READOUT) ||
				(pushing && state_reg == sys_cmd_pkg::S_CHUNK && remain > chunk_len);
		end
	end

	// outgoing buffer decouples the sequencer from the transport
	msg_fifo #(
		.WIDTH($bits(sys_cmd_pkg::msg_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.reset(reset),
		.in_valid(pushing),
		.in_ready(fifo_in_ready),
		.in_data(out_reg),
		.out_valid(msg_valid),
		.out_ready(msg_ready),
		.out_data(msg_data)
	);
endmodule // system_command_handler

`default_nettype wire

// *** core/sys_cmd_pkg.sv ***
// constants and message types for the system command handler
// assumes a 100 MHz system clock and a framer that decodes commands upstream
// Functional notes
// RULE_01 - a liveness query is answered straight away with a well-formed response
// RULE_02 - liveness response carries 32-bit whole seconds since boot
// RULE_03 - liveness response carries 16-bit fraction in 1/32768 second units
// RULE_04 - runtime is counted from the internal 32768 Hz watch tick
// RULE_05 - a liveness query changes nothing except producing its response
// RULE_06 - restart command restarts at once; unsaved settings and links are dropped
// RULE_07 - a startup event is sent once a commanded restart completes
// RULE_08 - readout sends chunk events of at most 16 bytes until the length is sent
// RULE_09 - readout selector 0 runtime, 1 boot, 2 factory configuration, 3 state
// RULE_10 - readout response length is 674 for configuration, 1955 for state
// RULE_11 - save command copies runtime settings into the boot configuration area
// RULE_12 - host saves settings only while no connection is open
// RULE_13 - defaults restore loads factory settings then restarts immediately
// RULE_14 - host returns its transport settings to factory values after a restore
// RULE_15 - defaults restore sends a reset-complete event, then startup after restart
// RULE_16 - messages use text format on mode 0 and binary format on mode 1
// RULE_17 - system group 2 commands 1 to 5 are routed and answered by identifier
// RULE_18 - a command's response goes out before any follow-on event sequence
package sys_cmd_pkg;
	localparam logic [7:0] GROUP_SYSTEM = 8'h02;
	localparam logic [7:0] CMD_PING = 8'h01;
	localparam logic [7:0] CMD_RESTART = 8'h02;
	localparam logic [7:0] CMD_READOUT = 8'h03;
	localparam logic [7:0] CMD_SAVE = 8'h04;
	localparam logic [7:0] CMD_DEFAULTS = 8'h05;
	localparam logic [7:0] EVT_BOOT = 8'h01;
	localparam logic [7:0] EVT_RESTORE_DONE = 8'h03;
	localparam logic [7:0] EVT_CHUNK = 8'h05;
	localparam logic [1:0] SEL_STATE = 2'h3;
	localparam logic [15:0] LEN_CONFIG = 16'h02A2;
	localparam logic [15:0] LEN_STATE = 16'h07A3;
	localparam logic [15:0] CHUNK_MAX = 16'h0010;
	localparam logic [15:0] RES_OK = 16'h0000;
	localparam logic [15:0] RES_UNKNOWN_CMD = 16'h0203;
	localparam logic [15:0] RES_BAD_VALUE = 16'h020C;
	localparam logic MODE_TEXT = 1'b0;
	localparam logic MODE_BINARY = 1'b1;
	localparam int CLK_HZ = 100_000_000;
	localparam int WATCH_HZ = 32_768;
	localparam logic [15:0] FRAC_LAST = 16'h7FFF;
	localparam int PAYLOAD_W = 128;

	typedef struct packed {
		logic [7:0] group;
		logic [7:0] id;
		logic [7:0] arg;
	} cmd_t;

	typedef struct packed {
		logic fmt; // 0 text, 1 binary
		logic is_event;
		logic [7:0] group;
		logic [7:0] id;
		logic [15:0] result;
		logic [15:0] len;
		logic [PAYLOAD_W-1:0] payload;
	} msg_t;

	typedef enum logic [9:0] {
		S_IDLE = 10'b00_0000_0001,
		S_RESP = 10'b00_0000_0010,
		S_SAVE = 10'b00_0000_0100,
		S_RDREQ = 10'b00_0000_1000,
		S_RDWAIT = 10'b00_0001_0000,
		S_CHUNK = 10'b00_0010_0000,
		S_DEFLT = 10'b00_0100_0000,
		S_DONEV = 10'b00_1000_0000,
		S_REBOOT = 10'b01_0000_0000,
		S_BOOT = 10'b10_0000_0000
	} state_t;
endpackage

// *** tb/sys_cmd_monitor.sv ***
// checker on the system command handler top ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sys_cmd_monitor (
	input wire logic clk_sys, // clock
	input wire logic reset, // sync reset
	input wire sys_cmd_pkg::cmd_t cmd_data, // command
	input wire logic cmd_valid, // offered
	input wire logic cmd_ready, // accepted
	input wire sys_cmd_pkg::msg_t msg_data, // fifo head
	input wire logic msg_valid, // head valid
	input wire logic restart_req, // restart pulse
	input wire logic save_req, // save pulse
	input wire logic defaults_req, // factory load pulse
	input wire logic [31:0] runtime_sec, // seconds
	input wire logic [15:0] runtime_frac // fraction
);
	// a system-group command accepted this cycle
	wire logic go = cmd_valid && cmd_ready && cmd_data.group == 8'h02;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	chk_ping_answered: assert property (go && cmd_data.id == 8'h01 |-> ##[1:4] msg_valid)
		else $error("ping left unanswered");
	chk_frac_range: assert property (runtime_frac <= 16'h7FFF)
		else $error("fraction beyond one second");
	chk_frac_step: assert property ($changed(runtime_frac) |->
		runtime_frac == 16'h0 || runtime_frac == $past(runtime_frac) + 16'h1)
		else $error("fraction skipped a tick");
	chk_sec_on_wrap: assert property ($changed(runtime_sec) && runtime_sec != 32'h0 |->
		$past(runtime_frac) == 16'h7FFF && runtime_frac == 16'h0)
		else $error("seconds moved without a wrap");
	chk_restart_issued: assert property (go && cmd_data.id == 8'h02 |-> ##[2:8] restart_req)
		else $error("restart not requested");
	chk_save_issued: assert property (go && cmd_data.id == 8'h04 |-> ##[1:4] save_req)
		else $error("save not requested");
	chk_defaults_issued: assert property (go && cmd_data.id == 8'h05 |-> ##[2:8] defaults_req)
		else $error("factory load not requested");
	chk_chunk_size: assert property (msg_valid && msg_data.is_event && msg_data.id == 8'h05 |->
		msg_data.len != 16'h0 && msg_data.len <= 16'h10)
		else $error("chunk length out of range");
endmodule // sys_cmd_monitor
`default_nettype wire

// *** tb/sys_far_model.sv ***
// far-side model: settings storage, restart sequencer and readout memory
// assumes the handler's one-cycle request pulses on the same clock
`timescale 1ns/1ps
`default_nettype none
module sys_far_model (
	input wire logic clk_sys, // clock
	input wire logic reset, // sync reset
	input wire logic slow, // long completion delays
	input wire logic restart_req, // restart pulse
	output logic restart_done, // restart finished
	input wire logic save_req, // save pulse
	output logic save_done, // save finished
	input wire logic defaults_req, // factory load pulse
	output logic defaults_done, // factory load finished
	input wire logic rd_req, // readout fetch
	input wire logic [1:0] rd_sel, // area
	input wire logic [15:0] rd_addr, // byte offset
	output logic [127:0] rd_data // fetched bytes
);
	logic [4:0] cnt_reg;
	logic [1:0] kind_reg;
	// one job at a time is enough, since the handler waits for each done
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_reg <= 5'h0;
			kind_reg <= 2'h0;
		end else if (restart_req || save_req || defaults_req) begin
			cnt_reg <= slow ? 5'h14 : 5'h3;
			kind_reg <= {defaults_req, save_req};
		end else if (cnt_reg != 5'h0) begin
			cnt_reg <= cnt_reg - 5'h1;
		end
	end
	assign restart_done = cnt_reg == 5'h1 && kind_reg == 2'h0;
	assign save_done = cnt_reg == 5'h1 && kind_reg == 2'h1;
	assign defaults_done = cnt_reg == 5'h1 && kind_reg == 2'h2;
	// data holds only in the cycle after a fetch; it flips otherwise so stale use shows
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rd_data <= 128'h0;
		end else if (rd_req) begin
			rd_data <= {8{rd_sel, rd_addr[13:0]}};
		end else begin
			rd_data <= ~rd_data;
		end
	end
endmodule // sys_far_model
`default_nettype wire

// *** tb/system_command_handler_test.sv ***
// self-checking bench for the system command handler
// assumes the far-side model for storage and readout; fifo depth cut to 4
`timescale 1ns/1ps
`default_nettype none
module system_command_handler_test;
	typedef struct packed {
		logic [7:0] g, id, arg;
		logic m;
		logic [15:0] res, ids, nch, tot;
	} row_t;
	// group, id, arg, mode, result, event ids, chunk count, byte total
	row_t rows [12] = '{'{8'h02, 8'h01, 8'h00, 1'b1, 16'h0, 16'h0, 16'h0, 16'h0},
		'{8'h02, 8'h03, 8'h00, 1'b0, 16'h0, 16'h0, 16'h2B, 16'h2A2},
		'{8'h02, 8'h03, 8'h01, 1'b1, 16'h0, 16'h0, 16'h2B, 16'h2A2},
		'{8'h02, 8'h03, 8'h02, 1'b0, 16'h0, 16'h0, 16'h2B, 16'h2A2},
		'{8'h02, 8'h03, 8'h03, 1'b1, 16'h0, 16'h0, 16'h7B, 16'h7A3},
		'{8'h02, 8'h03, 8'h04, 1'b0, 16'h20C, 16'h0, 16'h0, 16'h0},
		'{8'h02, 8'h04, 8'h00, 1'b1, 16'h0, 16'h0, 16'h0, 16'h0},
		'{8'h03, 8'h01, 8'h00, 1'b0, 16'h203, 16'h0, 16'h0, 16'h0},
		'{8'h02, 8'h06, 8'h00, 1'b1, 16'h203, 16'h0, 16'h0, 16'h0},
		'{8'h02, 8'h00, 8'h00, 1'b0, 16'h203, 16'h0, 16'h0, 16'h0},
		'{8'h02, 8'h02, 8'h00, 1'b1, 16'h0, 16'h1, 16'h0, 16'h0},
		'{8'h02, 8'h05, 8'h00, 1'b0, 16'h0, 16'h301, 16'h0, 16'h0}};
	logic clk_sys = 1'b0, reset = 1'b1, parse_mode = 1'b0, cmd_valid = 1'b0;
	logic msg_ready = 1'b1, slow = 1'b0;
	logic cmd_ready, msg_valid, restart_req, restart_done, save_req, save_done;
	logic defaults_req, defaults_done, rd_req;
	logic [1:0] rd_sel;
	logic [15:0] rd_addr, runtime_frac, off, ids, ef;
	logic [127:0] rd_data;
	logic [31:0] runtime_sec;
	logic [47:0] rt;
	sys_cmd_pkg::cmd_t cmd_data = '0;
	sys_cmd_pkg::msg_t msg_data, m;
	sys_cmd_pkg::msg_t q[$];
	int mismatches = 0, check_count = 0, cyc = 0, n, k;
	always #5 clk_sys = ~clk_sys;
	// transport side: every message popped is queued for inspection
	always @(posedge clk_sys) begin
		cyc <= reset ? 0 : cyc + 1;
		if (msg_valid && msg_ready) q.push_back(msg_data);
	end
	system_command_handler #(.FIFO_DEPTH(4)) i_dut (.clk_sys(clk_sys), .reset(reset),
		.parse_mode(parse_mode), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .msg_data(msg_data), .msg_valid(msg_valid),
		.msg_ready(msg_ready), .restart_req(restart_req), .restart_done(restart_done),
		.save_req(save_req), .save_done(save_done), .defaults_req(defaults_req),
		.defaults_done(defaults_done), .rd_req(rd_req), .rd_sel(rd_sel), .rd_addr(rd_addr),
		.rd_data(rd_data), .runtime_sec(runtime_sec), .runtime_frac(runtime_frac));
	sys_far_model i_far (.clk_sys(clk_sys), .reset(reset), .slow(slow),
		.restart_req(restart_req), .restart_done(restart_done), .save_req(save_req),
		.save_done(save_done), .defaults_req(defaults_req), .defaults_done(defaults_done),
		.rd_req(rd_req), .rd_sel(rd_sel), .rd_addr(rd_addr), .rd_data(rd_data));
	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic fail_to();
		mismatches++;
		$display("Error %0t: wait ran out", $time);
		end_sim();
	endtask
	// holds the command until the edge that takes it, noting runtime there
	task automatic send(input logic [7:0] g, id, arg);
		cmd_data = '{g, id, arg};
		cmd_valid = 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (cmd_ready !== 1'b1 && n < 300);
		if (n == 300) fail_to();
		rt = {runtime_sec, runtime_frac};
		ef = 16'(longint'(cyc) * 32768 / 100000000);
		#1 cmd_valid = 1'b0;
	endtask
	task automatic settle();
		n = 0;
		while (!(cmd_ready === 1'b1 && msg_valid === 1'b0) && n < 5000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n == 5000) fail_to();
		#1;
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		#1 reset = 1'b0;
		settle();
		m = q.pop_front();
		check({m.is_event, m.group, m.id}, {1'b1, 8'h02, 8'h01});
		repeat (20000) @(posedge clk_sys);
		#1 send(8'h02, 8'h01, 8'h00);
		settle();
		m = q.pop_front();
		check(m.payload[47:0], rt);
		check(rt[15:0] + 16'h1 - ef <= 16'h2, 48'h1);
		$display("runtime test done");
		foreach (rows[i]) begin
			parse_mode = rows[i].m;
			slow = i[0];
			send(rows[i].g, rows[i].id, rows[i].arg);
			settle();
			m = q.pop_front();
			check({m.fmt, m.is_event, m.group, m.id, m.result},
				{rows[i].m, 1'b0, rows[i].g, rows[i].id, rows[i].res});
			if (rows[i].id == 8'h03) check(m.len, rows[i].tot);
			if (rows[i].ids != 16'h0) check({runtime_sec, runtime_frac}, 48'h0);
			k = 0;
			off = 16'h0;
			ids = 16'h0;
			while (q.size() > 0) begin
				m = q.pop_front();
				if (m.id == 8'h05) begin
					check({m.len, m.payload[15:0]}, {(rows[i].tot - off > 16'h10) ? 16'h10 :
						rows[i].tot - off, rows[i].arg[1:0], off[13:0]});
					off = off + m.len;
					k++;
				end else ids = {ids[7:0], m.id};
			end
			check({k[15:0], off, ids}, {rows[i].nch, rows[i].tot, rows[i].ids});
			$display("row %0d done", i);
		end
		// transport stalls: fifo fills, sequencer must wait and lose nothing
		msg_ready = 1'b0;
		send(8'h02, 8'h03, 8'h03);
		repeat (300) @(posedge clk_sys);
		check({msg_valid, cmd_ready}, 48'h2);
		#1 msg_ready = 1'b1;
		settle();
		check(q.size(), 48'd124);
		q.delete();
		$display("stall test done");
		// reset in mid readout restarts cleanly with a fresh startup event
		send(8'h02, 8'h03, 8'h00);
		repeat (30) @(posedge clk_sys);
		#1 reset = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1 check({cmd_ready, msg_valid, rd_req, runtime_frac}, 48'h0);
		reset = 1'b0;
		q.delete();
		settle();
		m = q.pop_front();
		check({m.is_event, m.id, q.size()}, {1'b1, 8'h01, 32'h0});
		$display("reset test done");
		end_sim();
	end
endmodule // system_command_handler_test
bind system_command_handler sys_cmd_monitor i_mon (.clk_sys(clk_sys), .reset(reset),
	.cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
	.msg_data(msg_data), .msg_valid(msg_valid), .restart_req(restart_req),
	.save_req(save_req), .defaults_req(defaults_req), .runtime_sec(runtime_sec),
	.runtime_frac(runtime_frac));
`default_nettype wire
